// file: hw/qstat_pkg.sv
/*
  Shared constants for the converter status readout scheduler: register
  offsets, field positions, reset values, timer counts and mode codes.
  Assumes a 20 MHz clock and a 32-bit AXI4-Lite register bus.
*/
package qstat_pkg;

  // Converters served by the block
  localparam int unsigned NUM_CONV = 4;

  // Register byte addresses
  localparam logic [7:0] OFS_CTRL0   = 8'h00;
  localparam logic [7:0] OFS_CTRL1   = 8'h04;
  localparam logic [7:0] OFS_CTRL2   = 8'h08;
  localparam logic [7:0] OFS_CTRL3   = 8'h0C;
  localparam logic [7:0] OFS_STAT0   = 8'h10;
  localparam logic [7:0] OFS_STAT1   = 8'h14;
  localparam logic [7:0] OFS_STAT2   = 8'h18;
  localparam logic [7:0] OFS_STAT3   = 8'h1C;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h20;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h24;
  localparam logic [7:0] OFS_ATIMER  = 8'h28;

  // Control register fields
  localparam int unsigned CTL_MODE_LSB = 0;
  localparam int unsigned CTL_RDSTAT   = 2;
  localparam int unsigned CTL_AUTO     = 3;
  localparam int unsigned CTL_ALERT_EN = 4;

  // Status register fields
  localparam int unsigned ST_VALID     = 16;
  localparam int unsigned ST_PEND      = 17;
  localparam int unsigned ST_THERM     = 4;
  localparam logic [15:0] ST_OC_MASK   = 16'h000F;
  localparam logic [15:0] ST_ALERT_MSK = 16'h001F;

  // Operating modes
  localparam logic [1:0] MODE_IMM   = 2'h0;
  localparam logic [1:0] MODE_MAN   = 2'h1;
  localparam logic [1:0] MODE_BUF   = 2'h2;
  localparam logic [1:0] MODE_TIMED = 2'h3;

  // Reset values
  localparam logic [4:0]  CTRL_RST   = 5'h00;
  localparam logic [15:0] ATIMER_RST = 16'h0064;

  // Auto status timer tick: 10 us per timer unit
  localparam int unsigned CLK_HZ    = 20_000_000;
  localparam int unsigned TICK_NS   = 10_000;
  localparam int unsigned TICK_CYC  = TICK_NS / (1_000_000_000 / CLK_HZ);

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : qstat_pkg

// file: hw/tick_div.sv
/*
  Divider that emits a one-cycle enable pulse every DIV cycles.
  Assumes a single clock and synchronous active-low reset.
*/
`timescale 1ns/1ns
module tick_div #(
  parameter int unsigned DIV = 200
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Enable pulse
  output logic      tick
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } div_state_t;

  div_state_t s_q;
  div_state_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 16'(DIV - 1)) begin
      s_d.cnt  = 16'h0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : tick_div

// file: hw/conv_sched.sv
/*
  Per-converter status read scheduler: holds the pending request, defers
  it behind data transfers and group loads, and drives the status fetch.
  Assumes the serial engine answers each fetch with a one-cycle done.
*/
`timescale 1ns/1ns
module conv_sched (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Configuration
  input  wire logic [1:0]  mode,
  input  wire logic        auto_en,
  input  wire logic        alert_en,
  // Request sources
  input  wire logic        man_req,
  input  wire logic        timer_exp,
  input  wire logic        seq_end,
  // Converter side
  input  wire logic        xfer_busy,
  input  wire logic        grp_wait,
  input  wire logic        fetch_done,
  input  wire logic [15:0] fetch_data,
  output logic             fetch_req,
  // Results
  output logic [15:0]      stat_word,
  output logic             stat_valid,
  output logic             pending,
  output logic             alert_evt
);

  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_FETCH} sched_st_t;

  typedef struct packed {
    sched_st_t   st;
    logic [15:0] word;
    logic        valid;
    logic        alert;
  } sched_t;

  sched_t s_q;
  sched_t s_d;
  logic   logged;
  logic   imm_man;

  assign imm_man = (mode == qstat_pkg::MODE_IMM) ||
                   (mode == qstat_pkg::MODE_MAN);
  assign logged  = (man_req && imm_man) ||
                   (auto_en && imm_man && timer_exp) ||
                   (auto_en && !imm_man && seq_end);

  always_comb begin
    s_d       = s_q;
    s_d.alert = 1'b0;
    unique case (s_q.st)
      S_IDLE: begin
        if (logged) begin
          s_d.st    = S_WAIT;
          s_d.valid = 1'b0;
        end
      end
      S_WAIT: begin
        if (!xfer_busy && !grp_wait) begin
          s_d.st = S_FETCH;
        end
      end
      S_FETCH: begin
        if (fetch_done) begin
          s_d.word  = fetch_data;
          s_d.valid = 1'b1;
          s_d.alert = alert_en &&
                      |(fetch_data & qstat_pkg::ST_ALERT_MSK);
          s_d.st    = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '{st: S_IDLE, word: 16'h0000, valid: 1'b0, alert: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign fetch_req  = (s_q.st == S_FETCH);
  assign stat_word  = s_q.word;
  assign stat_valid = s_q.valid;
  assign pending    = (s_q.st != S_IDLE);
  assign alert_evt  = s_q.alert;

  a_valid_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.st == S_IDLE && logged) |=> !s_q.valid)
    else $error("valid not cleared on logged request");
  a_valid_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.st == S_FETCH && fetch_done) |=> s_q.valid)
    else $error("valid not set after fetch");
  a_defer_xfer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.st == S_WAIT && (xfer_busy || grp_wait)) |=>
      s_q.st == S_WAIT)
    else $error("status read not deferred");
  a_no_man_buf: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.st == S_IDLE && man_req && !imm_man && !seq_end) |=>
      s_q.st == S_IDLE)
    else $error("manual read taken in buffered mode");

endmodule : conv_sched

// file: hw/qstat_top.sv
/*
  Status readout scheduler for four quad converters with an AXI4-Lite
  register slave, alert interrupt collection and auto status timer.
  Assumes the serial engine signals per-converter transfer busy, group
  load wait, sequence end and fetch completion on the aclk domain.
*/
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Manual reads only in immediate/manual-load modes
// - Request bit write logs pending status read
// - Logging a request clears status valid
// - Valid set again after status fetch completes
// - Pending read waits for data transfer end
// - Pending read waits for group load end
// - Auto reads enabled per converter, all modes
// - Timer expiry logs request, timer restarts
// - Buffered/timed modes: one update per sequence
// - Thermal or overcurrent status raises interrupt
// - Per-converter alert bit on alert status
// - Bipolar codes are two's complement
// - Unipolar codes are straight binary
module qstat_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial engine, one bit per converter, fetch_data 16 bits per converter
  input  wire logic [3:0]  xfer_busy,
  input  wire logic [3:0]  grp_wait,
  input  wire logic [3:0]  seq_end,
  input  wire logic [3:0]  fetch_done,
  input  wire logic [63:0] fetch_data,
  output logic [3:0]       fetch_req,
  // Interrupt
  output logic             alert_interrupt
);

  localparam int unsigned N = qstat_pkg::NUM_CONV;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        aw_held;
    logic        w_held;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [3:0][4:0] ctrl;
    logic [3:0]  irq_st;
    logic [3:0]  irq_msk;
    logic [15:0] atimer;
    logic [15:0] tcnt;
    logic        irq;
    logic [3:0]  fetch_req;
    logic [3:0]  stat_req;
  } top_t;

  top_t s_q;
  top_t s_d;

  logic            tick;
  logic [3:0]      man_req;
  logic            timer_exp;
  logic [3:0]      pend;
  logic [3:0]      valid;
  logic [3:0]      alert_evt;
  logic [3:0]      freq;
  logic [3:0][15:0] words;
  logic            wr_go;
  logic            rd_go;

  ////////////////////////////////////////////////////////////////////////
  // Auto status timer and per-converter schedulers

  tick_div #(
    .DIV (qstat_pkg::TICK_CYC)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  assign timer_exp = tick && (s_q.tcnt == 16'h0000);

  generate
    for (genvar i = 0; i < N; i++) begin : g_conv
      conv_sched u_sched (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .mode       (s_q.ctrl[i][1:0]),
        .auto_en    (s_q.ctrl[i][qstat_pkg::CTL_AUTO]),
        .alert_en   (s_q.ctrl[i][qstat_pkg::CTL_ALERT_EN]),
        .man_req    (s_q.stat_req[i]),
        .timer_exp  (timer_exp),
        .seq_end    (seq_end[i]),
        .xfer_busy  (xfer_busy[i]),
        .grp_wait   (grp_wait[i]),
        .fetch_done (fetch_done[i]),
        .fetch_data (fetch_data[16*i +: 16]),
        .fetch_req  (freq[i]),
        .stat_word  (words[i]),
        .stat_valid (valid[i]),
        .pending    (pend[i]),
        .alert_evt  (alert_evt[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Register bus

  assign wr_go = s_q.aw_held && s_q.w_held && !s_q.bvalid;
  assign rd_go = s_axi_arvalid && s_q.arready;

  // Manual request pulse from a write of the request bit
  always_comb begin
    man_req = 4'h0;
    if (wr_go && s_q.wstrb[0] && s_q.wdata[qstat_pkg::CTL_RDSTAT]) begin
      for (int i = 0; i < N; i++) begin
        if (s_q.awaddr == 8'(4 * i)) begin
          man_req[i] = 1'b1;
        end
      end
    end
  end

  function automatic logic [31:0] rd_mux(input top_t s,
                                         input logic [7:0] a,
                                         input logic [3:0] v,
                                         input logic [3:0] p,
                                         input logic [3:0][15:0] w);
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      if (a == 8'(4 * i)) begin
        r = {27'h0, s.ctrl[i]};
      end
      if (a == 8'(8'h10 + 4 * i)) begin
        r = {14'h0, p[i], v[i], w[i]};
      end
    end
    if (a == qstat_pkg::OFS_IRQ_ST) begin
      r = {28'h0, s.irq_st};
    end
    if (a == qstat_pkg::OFS_IRQ_MSK) begin
      r = {28'h0, s.irq_msk};
    end
    if (a == qstat_pkg::OFS_ATIMER) begin
      r = {16'h0, s.atimer};
    end
    return r;
  endfunction : rd_mux

  function automatic logic known(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= qstat_pkg::OFS_ATIMER);
  endfunction : known

  always_comb begin
    s_d = s_q;
    // Write address and data taken in either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_held = 1'b1;
      s_d.awaddr  = s_axi_awaddr;
      s_d.awready = 1'b0;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_held = 1'b1;
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb  = s_axi_wstrb;
      s_d.wready = 1'b0;
    end
    if (wr_go) begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = known(s_q.awaddr) ? qstat_pkg::RESP_OKAY
                                      : qstat_pkg::RESP_SLVERR;
      for (int i = 0; i < N; i++) begin
        if (s_q.awaddr == 8'(4 * i) && s_q.wstrb[0]) begin
          // Request bit is a strobe, not stored
          s_d.ctrl[i] = s_q.wdata[4:0] &
                        ~(5'h01 << qstat_pkg::CTL_RDSTAT);
        end
      end
      if (s_q.awaddr == qstat_pkg::OFS_IRQ_MSK && s_q.wstrb[0]) begin
        s_d.irq_msk = s_q.wdata[3:0];
      end
      if (s_q.awaddr == qstat_pkg::OFS_ATIMER) begin
        if (s_q.wstrb[0]) s_d.atimer[7:0] = s_q.wdata[7:0];
        if (s_q.wstrb[1]) s_d.atimer[15:8] = s_q.wdata[15:8];
      end
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid  = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready  = 1'b1;
    end
    // Read channel
    if (rd_go) begin
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rdata   = rd_mux(s_q, s_axi_araddr, valid, pend, words);
      s_d.rresp   = known(s_axi_araddr) ? qstat_pkg::RESP_OKAY
                                        : qstat_pkg::RESP_SLVERR;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end
    // Cyclic timer reloads on expiry
    if (tick) begin
      s_d.tcnt = (s_q.tcnt == 16'h0000) ? s_q.atimer
                                        : s_q.tcnt - 16'h0001;
    end
    // Sticky alert bits: clear by writing one, set wins
    if (wr_go && s_q.awaddr == qstat_pkg::OFS_IRQ_ST && s_q.wstrb[0]) begin
      s_d.irq_st = s_q.irq_st & ~s_q.wdata[3:0];
    end
    s_d.irq_st    = s_d.irq_st | alert_evt;
    s_d.irq       = |(s_d.irq_st & s_d.irq_msk);
    s_d.fetch_req = freq;
    // Request strobe waits a cycle so the scheduler sees the new mode
    s_d.stat_req  = man_req;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q         <= '0;
      s_q.awready <= 1'b1;
      s_q.wready  <= 1'b1;
      s_q.arready <= 1'b1;
      s_q.atimer  <= qstat_pkg::ATIMER_RST;
      s_q.tcnt    <= qstat_pkg::ATIMER_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready   = s_q.awready;
  assign s_axi_wready    = s_q.wready;
  assign s_axi_bvalid    = s_q.bvalid;
  assign s_axi_bresp     = s_q.bresp;
  assign s_axi_arready   = s_q.arready;
  assign s_axi_rvalid    = s_q.rvalid;
  assign s_axi_rdata     = s_q.rdata;
  assign s_axi_rresp     = s_q.rresp;
  assign alert_interrupt = s_q.irq;
  assign fetch_req       = s_q.fetch_req;

  // Codes pass to the converter untouched in both range kinds

  ////////////////////////////////////////////////////////////////////////
  // Checks

  a_alert_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    alert_evt[0] |=> s_q.irq_st[0])
    else $error("alert event not captured");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    (alert_evt[0] && s_q.irq_msk[0] && !wr_go) |=> alert_interrupt)
    else $error("interrupt not raised");
  a_timer_req: assert property (@(posedge aclk) disable iff (!aresetn)
    (timer_exp && s_q.ctrl[3][3] && !s_q.ctrl[3][1] && !pend[3])
      |=> pend[3] && !valid[3])
    else $error("timer expiry did not log request");
  a_timer_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_exp |=> s_q.tcnt == $past(s_q.atimer))
    else $error("timer not restarted");
  a_seq_req: assert property (@(posedge aclk) disable iff (!aresetn)
    (seq_end[2] && s_q.ctrl[2][3] && s_q.ctrl[2][1] && !pend[2])
      |=> pend[2])
    else $error("sequence end did not log request");
  a_grp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    grp_wait[2] |-> ##1 !(freq[2] && !$past(freq[2])))
    else $error("fetch started during group wait");
  a_man_req: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.stat_req[2] && !s_q.ctrl[2][1] && !pend[2]) |=> pend[2])
    else $error("manual request not logged");

endmodule : qstat_top

// file: verif/conv_model.sv
/*
  Behavioural model of the four converter chips behind the serial engine.
  Answers each fetch request with a one-cycle done after DELAY cycles.
  Assumes the bench supplies the status words and the shared clock/reset.
*/
`timescale 1ns/1ns
module conv_model #(
  parameter int DELAY = 20
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Fetch handshake
  input  wire logic [3:0]  fetch_req,
  input  wire logic [63:0] stat_in,
  output logic [3:0]       fetch_done,
  output logic [63:0]      fetch_data
);
  int          cnt_q [4];
  logic [3:0]  served_q;
  logic [63:0] last_q;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      fetch_done[i] <= 1'b0;
      if (!aresetn || !fetch_req[i]) begin
        served_q[i] <= 1'b0;
        cnt_q[i]    <= 0;
      end else if (!served_q[i]) begin
        if (cnt_q[i] == DELAY) begin
          fetch_done[i]        <= 1'b1;
          served_q[i]          <= 1'b1;
          last_q[16*i +: 16]   <= stat_in[16*i +: 16];
        end else begin
          cnt_q[i] <= cnt_q[i] + 1;
        end
      end
    end
    if (!aresetn) begin
      last_q <= 64'h0;
    end
  end

  // Data lines invert outside the done cycle so stale values never match
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      fetch_data[16*i +: 16] = fetch_done[i] ? last_q[16*i +: 16]
                                             : ~last_q[16*i +: 16];
    end
  end
endmodule : conv_model

// file: verif/test_dac_status_poll_and_coding.sv
/*
  Self-checking bench for the converter status readout scheduler.
  Assumes qstat_top with its package and the converter model beside it.
*/
`timescale 1ns/1ns
module test_dac_status_poll_and_coding;
  localparam logic [31:0] RD = 32'h1 << qstat_pkg::CTL_RDSTAT;
  localparam logic [31:0] AU = 32'h1 << qstat_pkg::CTL_AUTO;
  localparam logic [31:0] AL = 32'h1 << qstat_pkg::CTL_ALERT_EN;
  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, alert_interrupt;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  xfer_busy, grp_wait, seq_end, fetch_done, fetch_req, fq_q;
  logic [63:0] fetch_data, stat_w;
  int          failures, tests_run, c;
  int          fetch_cnt [4];
  logic [31:0] row_ctl [4];
  logic [15:0] row_st [4];
  logic        row_irq [4];

  qstat_top qstat_top_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .xfer_busy(xfer_busy),
    .grp_wait(grp_wait), .seq_end(seq_end), .fetch_done(fetch_done),
    .fetch_data(fetch_data), .fetch_req(fetch_req),
    .alert_interrupt(alert_interrupt));

  conv_model #(.DELAY(20)) conv_model_inst (
    .aclk(aclk), .aresetn(aresetn), .fetch_req(fetch_req),
    .stat_in(stat_w), .fetch_done(fetch_done), .fetch_data(fetch_data));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      if (fetch_req[i] && !fq_q[i]) fetch_cnt[i]++;
    end
    fq_q <= fetch_req;
  end

  task automatic print_verdict();
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Host side code correction, floating point, saturated to the range
  function automatic logic [15:0] host_corr(input int      v,
                                            input shortint g,
                                            input shortint o,
                                            input bit      bip);
    real r;
    r = v * (1.0 - g / (bip ? 131072.0 : 262144.0)) - o / 4.0;
    if (bip) begin
      r = (r > 32767.0) ? 32767.0 : ((r < -32768.0) ? -32768.0 : r);
    end else begin
      r = (r > 65535.0) ? 65535.0 : ((r < 0.0) ? 0.0 : r);
    end
    return 16'(longint'(r));
  endfunction : host_corr

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 200) failures++;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (n < 200) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 200) failures++;
  endtask : rd

  task automatic defer(input int i, input bit g);
    @(posedge aclk);
    if (g) grp_wait[i] <= 1'b1;
    else xfer_busy[i] <= 1'b1;
    wr(qstat_pkg::OFS_CTRL0 + 8'(4*i), 32'(qstat_pkg::MODE_MAN) | RD);
    cyc(30);
    rd(qstat_pkg::OFS_STAT0 + 8'(4*i));
    chk(32'(d[17:16]), 32'h2);
    chk(32'(fetch_req[i]), 32'h0);
    @(posedge aclk);
    grp_wait[i] <= 1'b0;
    xfer_busy[i] <= 1'b0;
    cyc(40);
    rd(qstat_pkg::OFS_STAT0 + 8'(4*i));
    chk(32'(d[17:16]), 32'h1);
  endtask : defer

  initial begin
    repeat (60000) @(posedge aclk);
    failures++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    wstrb = 4'hF; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; xfer_busy = 4'h0; grp_wait = 4'h0;
    seq_end = 4'h0; stat_w = 64'h0; fq_q = 4'h0; failures = 0;
    tests_run = 0; fetch_cnt = '{0, 0, 0, 0};
    row_ctl = '{32'(qstat_pkg::MODE_IMM) | RD | AL,
                32'(qstat_pkg::MODE_MAN) | RD | AL,
                32'(qstat_pkg::MODE_IMM) | RD,
                32'(qstat_pkg::MODE_MAN) | RD | AL};
    row_st  = '{16'h0010, 16'h0001, 16'h0008, 16'h0120};
    row_irq = '{1'b1, 1'b1, 1'b0, 1'b0};
    cyc(10);
    aresetn <= 1'b1;
    rd(qstat_pkg::OFS_CTRL0);
    chk(d, 32'h0);
    rd(qstat_pkg::OFS_ATIMER);
    chk(d, 32'(qstat_pkg::ATIMER_RST));
    rd(8'h2C);
    chk({d[31:2], resp}, 32'(qstat_pkg::RESP_SLVERR));
    wr(8'h30, 32'hFFFF_FFFF);
    chk(32'(resp), 32'(qstat_pkg::RESP_SLVERR));
    wr(qstat_pkg::OFS_ATIMER, 32'h1);
    wr(qstat_pkg::OFS_IRQ_MSK, 32'hF);
    for (int i = 0; i < 4; i++) begin
      stat_w[16*i +: 16] = row_st[i];
      wr(qstat_pkg::OFS_CTRL0 + 8'(4*i), row_ctl[i]);
      rd(qstat_pkg::OFS_STAT0 + 8'(4*i));
      chk(32'(d[17:16]), 32'h2);
      cyc(40);
      rd(qstat_pkg::OFS_STAT0 + 8'(4*i));
      chk(d, {14'h0, 2'b01, row_st[i]});
      rd(qstat_pkg::OFS_IRQ_ST);
      chk(32'(d[i]), 32'(row_irq[i]));
    end
    chk(32'(alert_interrupt), 32'h1);
    wr(qstat_pkg::OFS_IRQ_ST, 32'h3);
    rd(qstat_pkg::OFS_IRQ_ST);
    chk(d, 32'h0);
    chk(32'(alert_interrupt), 32'h0);
    wr(qstat_pkg::OFS_IRQ_MSK, 32'h0);
    wr(qstat_pkg::OFS_CTRL0, row_ctl[0]);
    cyc(40);
    rd(qstat_pkg::OFS_IRQ_ST);
    chk(d, 32'h1);
    chk(32'(alert_interrupt), 32'h0);
    wr(qstat_pkg::OFS_IRQ_MSK, 32'h1);
    cyc(3);
    chk(32'(alert_interrupt), 32'h1);
    wr(qstat_pkg::OFS_IRQ_ST, 32'h1);
    cyc(3);
    chk(32'(alert_interrupt), 32'h0);
    // Manual requests refused in buffered and timed modes
    for (int m = 2; m < 4; m++) begin
      c = fetch_cnt[0];
      wr(qstat_pkg::OFS_CTRL0, 32'(m) | RD);
      cyc(40);
      rd(qstat_pkg::OFS_STAT0);
      chk(32'(d[17:16]), 32'h1);
      chk(32'(fetch_cnt[0] - c), 32'h0);
    end
    defer(1, 1'b0);
    defer(2, 1'b1);
    // Auto reads on the cyclic timer, then disabled
    c = fetch_cnt[3];
    wr(qstat_pkg::OFS_CTRL3, 32'(qstat_pkg::MODE_MAN) | AU);
    for (int n = 0; n < 22000 && fetch_cnt[3] == c; n++) @(posedge aclk);
    c = fetch_cnt[3];
    cyc(1000);
    chk(32'(fetch_cnt[3] - c), 32'h2);
    wr(qstat_pkg::OFS_CTRL3, 32'(qstat_pkg::MODE_MAN));
    cyc(30);
    c = fetch_cnt[3];
    cyc(600);
    chk(32'(fetch_cnt[3] - c), 32'h0);
    // One update per sequence, timer ignored
    for (int m = 2; m < 4; m++) begin
      wr(qstat_pkg::OFS_CTRL2, 32'(m) | AU);
      c = fetch_cnt[2];
      for (int k = 0; k < 2; k++) begin
        cyc(100);
        seq_end[2] <= 1'b1;
        @(posedge aclk);
        seq_end[2] <= 1'b0;
      end
      cyc(400);
      chk(32'(fetch_cnt[2] - c), 32'h2);
    end
    // Correction pairs differ per range; signed quarter-LSB values
    chk(32'(host_corr(32768, 0, 0, 1'b0)), 32'h8000);
    chk(32'(host_corr(32768, 8192, 4, 1'b0)), 32'h7BFF);
    chk(32'(host_corr(65535, 0, -4, 1'b0)), 32'hFFFF);
    chk(32'(host_corr(16384, 4096, -8, 1'b1)), 32'h3E02);
    chk(32'(host_corr(-32768, -4096, 0, 1'b1)), 32'h8000);
    print_verdict();
  end
endmodule : test_dac_status_poll_and_coding
